// ---- logic/psmc_top.sv ----
// The register addresses and register access over APB were decided locally.
`timescale 1ns/100ps
`default_nettype none
module psmc_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic lprcClk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pwrSaveExec,
  input wire logic pwrSaveSleep,
  input wire logic intPending,
  input wire logic wdtEnable,
  input wire logic fscmEnable,
  input wire logic wdtTimeout,
  input wire logic [2:0] curOscSel,
  input wire logic onChipOsc,
  input wire logic [psmc_pkg::NUM_MOD-1:0] extClocked,
  output logic sysClkRun,
  output logic oscEnable,
  output logic lprcEnable,
  output logic fscmActive,
  output logic wdtClear,
  output logic cpuClkEn,
  output logic [psmc_pkg::NUM_MOD-1:0] perClkEn,
  output logic [psmc_pkg::NUM_MOD-1:0] perFuncEn,
  output logic [psmc_pkg::NUM_MOD-1:0] perRegBlock,
  output logic [2:0] resumeOscSel,
  output logic wakeEvent
);
  import psmc_pkg::*;

  typedef struct packed {
    psmc_mode_t mode;
    logic return_on_interrupt;
    logic [2:0] ratio;
    logic clock_reduction_enable;
    logic [NUM_MOD-1:0] module_disable_bit;
    logic [NUM_MOD-1:0] idl;
    logic [NUM_MOD-1:0] en;
    logic [7:0] cnt;
    logic cpuEn;
    logic wdtClr;
    logic [2:0] savedOsc;
    logic wake;
    logic [31:0] rdata;
  } psmc_state_t;

  psmc_state_t st_r, st_nxt;
  logic [1:0] intSync_r, wdtSync_r;
  logic wakeReq;

  function automatic logic [7:0] ratio_limit(input logic [2:0] r);
    ratio_limit = 8'(({1'b0, 8'h01} << r) - 9'h001);
  endfunction : ratio_limit

  // wake sources resynchronised on the free-running rc clock
  always_ff @(posedge lprcClk) begin
    intSync_r <= {intSync_r[0], intPending};
    wdtSync_r <= {wdtSync_r[0], wdtTimeout};
  end

  // sleep uses the rc path; idle and run use the system clock directly
  assign wakeReq = (st_r.mode == PSMC_SLEEP) ?
    (intSync_r[1] | wdtSync_r[1]) : (intPending | wdtTimeout);

  wire apbWr = psel & penable & pwrite;
  wire apbRd = psel & ~penable & ~pwrite;

  always_comb begin
    st_nxt = st_r;
    st_nxt.wdtClr = 1'b0;
    st_nxt.wake = 1'b0;
    case (st_r.mode)
      PSMC_RUN: begin
        if (pwrSaveExec) begin
          st_nxt.wdtClr = wdtEnable;
          st_nxt.savedOsc = curOscSel;
          st_nxt.mode = pwrSaveSleep ? PSMC_SLEEP : PSMC_IDLE;
        end
      end
      PSMC_IDLE, PSMC_SLEEP: begin
        // pending interrupt held until entry completes, then wakes
        if (wakeReq) begin
          st_nxt.mode = PSMC_RUN;
          st_nxt.wake = 1'b1;
        end
      end
      default: st_nxt.mode = PSMC_RUN;
    endcase
    if (intPending && st_r.return_on_interrupt && st_r.mode == PSMC_RUN) begin
      st_nxt.clock_reduction_enable = 1'b0;
    end
    // entry and wake cycles bypass the divider so the cpu restarts at once
    if (st_r.clock_reduction_enable && st_r.mode == PSMC_RUN &&
        st_nxt.mode == PSMC_RUN) begin
      if (st_r.cnt >= ratio_limit(st_r.ratio)) begin
        st_nxt.cnt = 8'h00;
        st_nxt.cpuEn = 1'b1;
      end else begin
        st_nxt.cnt = 8'(st_r.cnt + 8'h01);
        st_nxt.cpuEn = 1'b0;
      end
    end else begin
      st_nxt.cnt = 8'h00;
      st_nxt.cpuEn = (st_nxt.mode == PSMC_RUN);
    end
    if (apbWr) begin
      case (paddr)
        CLOCK_DIVIDER_REGISTER_ADDR: begin
          st_nxt.return_on_interrupt = pwdata[ROI_BIT];
          st_nxt.ratio = pwdata[RATIO_HI:RATIO_LO];
          st_nxt.clock_reduction_enable = pwdata[CLOCK_REDUCTION_ENABLE_BIT];
        end
        PMD_ADDR: st_nxt.module_disable_bit = pwdata[NUM_MOD-1:0];
        IDL_ADDR: st_nxt.idl = pwdata[NUM_MOD-1:0];
        // enable bits stay writable unless the module is disabled
        EN_ADDR: st_nxt.en = (pwdata[NUM_MOD-1:0] & ~st_r.module_disable_bit) |
          (st_r.en & st_r.module_disable_bit);
        default: ;
      endcase
    end
    if (apbRd) begin
      case (paddr)
        CLOCK_DIVIDER_REGISTER_ADDR: st_nxt.rdata = {16'h0000, st_r.return_on_interrupt, st_r.ratio,
          st_r.clock_reduction_enable, 11'h000};
        PMD_ADDR: st_nxt.rdata = {24'h000000, st_r.module_disable_bit};
        IDL_ADDR: st_nxt.rdata = {24'h000000, st_r.idl};
        EN_ADDR: st_nxt.rdata = (st_r.module_disable_bit != '0) ? BAD_READ :
          {24'h000000, st_r.en};
        STAT_ADDR: st_nxt.rdata = {26'h0, st_r.savedOsc, st_r.mode};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '{mode: PSMC_RUN, return_on_interrupt: 1'b0, ratio: RATIO_RST, clock_reduction_enable: 1'b0,
        module_disable_bit: MOD_RST, idl: MOD_RST, en: EN_RST, cnt: 8'h00, cpuEn: 1'b1,
        wdtClr: 1'b0, savedOsc: 3'h0, wake: 1'b0, rdata: 32'h0000_0000};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign sysClkRun = (st_r.mode != PSMC_SLEEP);
  assign oscEnable = (st_r.mode != PSMC_SLEEP) | ~onChipOsc;
  assign lprcEnable = (st_r.mode == PSMC_SLEEP) ? wdtEnable :
    (wdtEnable | fscmEnable);
  assign fscmActive = fscmEnable & (st_r.mode != PSMC_SLEEP);
  assign wdtClear = st_r.wdtClr;
  assign cpuClkEn = st_r.cpuEn;
  assign resumeOscSel = st_r.savedOsc;
  assign wakeEvent = st_r.wake;

  genvar g;
  generate
    for (g = 0; g < NUM_MOD; g++) begin : gMod
      always_comb begin
        perClkEn[g] = ~st_r.module_disable_bit[g];
        if (st_r.mode == PSMC_SLEEP) begin
          perClkEn[g] = ~st_r.module_disable_bit[g] & extClocked[g];
        end else if (st_r.mode == PSMC_IDLE && st_r.idl[g]) begin
          perClkEn[g] = 1'b0;
        end
      end
      assign perFuncEn[g] = st_r.en[g] & perClkEn[g];
      assign perRegBlock[g] = st_r.module_disable_bit[g];
    end
  endgenerate

  a_sleep_clk_off: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_SLEEP) |-> !sysClkRun && !fscmActive)
    else $error("clock running in sleep");
  a_entry_wdt_clr: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_RUN && pwrSaveExec && wdtEnable) |=> wdtClear)
    else $error("watchdog not cleared on entry");
  a_entry_instr: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_RUN && !pwrSaveExec) |=> st_r.mode == PSMC_RUN)
    else $error("low power entered without instruction");
  a_idle_wake: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_IDLE && intPending) |=> cpuClkEn ##0 wakeEvent)
    else $error("idle wake failed");
  a_low_power_rc_oscillator_sleep: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_SLEEP && wdtEnable) |-> lprcEnable)
    else $error("rc oscillator off in sleep");
  a_doze_off: assert property (@(posedge ref_clk) disable iff (rst)
    (!st_r.clock_reduction_enable && st_r.mode == PSMC_RUN) |=>
    (st_r.mode != PSMC_RUN) || cpuClkEn || st_r.clock_reduction_enable)
    else $error("cpu gated without reduction");
  a_halt_stop: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_IDLE) |-> ((perClkEn & st_r.idl) == '0))
    else $error("module runs in halt despite stop bit");
  a_pmd_clk: assert property (@(posedge ref_clk) disable iff (rst)
    ((perClkEn & st_r.module_disable_bit) == '0))
    else $error("disabled module clocked");

  // entry into the two low-power modes
  a_idle_entry: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_RUN && pwrSaveExec && !pwrSaveSleep) |=>
    (st_r.mode == PSMC_IDLE && sysClkRun && !cpuClkEn))
    else $error("idle entry failed");
  a_sleep_entry: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_RUN && pwrSaveExec && pwrSaveSleep) |=>
    (st_r.mode == PSMC_SLEEP && !cpuClkEn && !sysClkRun))
    else $error("sleep entry failed");
  a_sleep_wdt_clr: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_RUN && pwrSaveExec && pwrSaveSleep && wdtEnable)
    |=> wdtClear)
    else $error("watchdog not cleared before sleep");
  a_no_wdt_clr: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_RUN && pwrSaveExec && !wdtEnable)
    |=> !wdtClear)
    else $error("watchdog cleared while disabled");
  a_wdt_clr_mode: assert property (@(posedge ref_clk) disable iff (rst)
    wdtClear
    |-> (st_r.mode != PSMC_RUN))
    else $error("watchdog clear outside entry");
  a_osc_saved: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_RUN && pwrSaveExec)
    |=> (resumeOscSel == $past(curOscSel)))
    else $error("clock source not saved");

  // clocks and oscillators while awake and in the low-power modes
  a_osc_run: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode != PSMC_SLEEP)
    |-> oscEnable)
    else $error("oscillator off while awake");
  a_osc_sleep: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_SLEEP && onChipOsc)
    |-> !oscEnable)
    else $error("on-chip oscillator left on in sleep");
  a_low_power_rc_oscillator_idle: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_IDLE && (wdtEnable || fscmEnable))
    |-> lprcEnable)
    else $error("rc oscillator off in halt");
  a_clock_failure_monitor_awake: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode != PSMC_SLEEP)
    |-> (fscmActive == fscmEnable))
    else $error("monitor state wrong while awake");
  a_halt_cpu: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_IDLE)
    |-> (!cpuClkEn && sysClkRun && oscEnable))
    else $error("cpu clocked in halt");
  a_sleep_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_SLEEP && !intSync_r[1] && !wdtSync_r[1])
    |=> (st_r.mode == PSMC_SLEEP && !cpuClkEn))
    else $error("sleep left without wake source");

  // peripheral clock gating
  a_sleep_per: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_SLEEP)
    |-> (perClkEn == (extClocked & ~st_r.module_disable_bit)))
    else $error("system-clocked module runs in sleep");
  a_run_per: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_RUN)
    |-> (perClkEn == ~st_r.module_disable_bit))
    else $error("module clock gated while running");
  a_idle_keep: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_IDLE)
    |-> ((perClkEn | st_r.idl | st_r.module_disable_bit) == '1))
    else $error("module stopped in halt without stop bit");

  // clock reduction
  a_cpu_cnt: assert property (@(posedge ref_clk) disable iff (rst)
    cpuClkEn
    |-> (st_r.cnt == 8'h00))
    else $error("cpu enable off the divider boundary");
  a_doze_step: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.clock_reduction_enable && st_r.mode == PSMC_RUN && !cpuClkEn)
    |-> (st_r.cnt != 8'h00))
    else $error("cpu gated on the divider boundary");
  a_clock_reduction_enable_wr: assert property (@(posedge ref_clk) disable iff (rst)
    (apbWr && paddr == CLOCK_DIVIDER_REGISTER_ADDR)
    |=> (st_r.clock_reduction_enable == $past(pwdata[CLOCK_REDUCTION_ENABLE_BIT])))
    else $error("reduction enable not written");
  a_ratio_wr: assert property (@(posedge ref_clk) disable iff (rst)
    (apbWr && paddr == CLOCK_DIVIDER_REGISTER_ADDR)
    |=> (st_r.ratio == $past(pwdata[RATIO_HI:RATIO_LO])))
    else $error("ratio not written");
  a_roi_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_RUN && st_r.return_on_interrupt && intPending && !apbWr)
    |=> !st_r.clock_reduction_enable)
    else $error("interrupt did not end reduction");
  a_roi_off: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_RUN && !st_r.return_on_interrupt && st_r.clock_reduction_enable && !apbWr)
    |=> st_r.clock_reduction_enable)
    else $error("reduction ended without return bit");

  // module register access
  a_en_locked: assert property (@(posedge ref_clk) disable iff (rst)
    (apbWr && paddr == EN_ADDR)
    |=> ((st_r.en & $past(st_r.module_disable_bit)) == ($past(st_r.en) & $past(st_r.module_disable_bit))))
    else $error("disabled module register written");
  a_pmd_read: assert property (@(posedge ref_clk) disable iff (rst)
    (apbRd && paddr == EN_ADDR && st_r.module_disable_bit != '0)
    |=> (prdata == BAD_READ))
    else $error("disabled module read returned data");
  a_en_write: assert property (@(posedge ref_clk) disable iff (rst)
    (apbWr && paddr == EN_ADDR && st_r.module_disable_bit == '0)
    |=> (st_r.en == $past(pwdata[NUM_MOD-1:0])))
    else $error("enable bits not writable");

  // wake-up
  a_defer_wake: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_RUN && pwrSaveExec && !pwrSaveSleep && intPending)
    ##1 intPending |=> (st_r.mode == PSMC_RUN && wakeEvent))
    else $error("coincident interrupt did not wake");
  a_wake_sleep: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_SLEEP && (intSync_r[1] || wdtSync_r[1]))
    |=> (st_r.mode == PSMC_RUN && wakeEvent))
    else $error("sleep wake failed");
  a_wdt_wake: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.mode == PSMC_IDLE && wdtTimeout)
    |=> (st_r.mode == PSMC_RUN))
    else $error("watchdog did not wake halt");
  a_wake_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    wakeEvent
    |-> (st_r.mode == PSMC_RUN && cpuClkEn) ##1 !wakeEvent)
    else $error("wake pulse wrong");
  c_sleep: cover property (@(posedge ref_clk) st_r.mode == PSMC_SLEEP);
  c_idle_wake: cover property (@(posedge ref_clk)
    st_r.mode == PSMC_IDLE ##1 wakeEvent);
  c_doze: cover property (@(posedge ref_clk) st_r.clock_reduction_enable && !cpuClkEn);
  c_sleep_wake: cover property (@(posedge ref_clk)
    st_r.mode == PSMC_SLEEP ##1 wakeEvent);
  c_pmd_read: cover property (@(posedge ref_clk)
    apbRd && paddr == EN_ADDR && st_r.module_disable_bit != '0);
endmodule : psmc_top
`default_nettype wire

// ---- include/psmc_pkg.sv ----
package psmc_pkg;
  localparam int NUM_MOD = 8;
  localparam logic [31:0] CLOCK_DIVIDER_REGISTER_ADDR = 32'h0000_0000;
  localparam logic [31:0] PMD_ADDR = 32'h0000_0004;
  localparam logic [31:0] IDL_ADDR = 32'h0000_0008;
  localparam logic [31:0] EN_ADDR = 32'h0000_000C;
  localparam logic [31:0] STAT_ADDR = 32'h0000_0010;
  localparam int ROI_BIT = 15;
  localparam int RATIO_HI = 14;
  localparam int RATIO_LO = 12;
  localparam int CLOCK_REDUCTION_ENABLE_BIT = 11;
  localparam logic [2:0] RATIO_RST = 3'h0;
  localparam logic [NUM_MOD-1:0] MOD_RST = 8'h00;
  localparam logic [NUM_MOD-1:0] EN_RST = 8'hFF;
  localparam logic [31:0] BAD_READ = 32'hDEAD_BEEF;
  typedef enum logic [2:0] {
    PSMC_RUN = 3'b001,
    PSMC_IDLE = 3'b010,
    PSMC_SLEEP = 3'b100
  } psmc_mode_t;
endpackage : psmc_pkg

// ---- tb/psmc_cpu_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module psmc_cpu_model (
  input wire logic ref_clk,
  input wire logic issue,
  input wire logic toSleep,
  output logic pwrSaveExec,
  output logic pwrSaveSleep
);
  initial pwrSaveExec = 1'b0;
  initial pwrSaveSleep = 1'b0;
  // the instruction strobe lasts one cycle, operand held with it
  always @(posedge ref_clk) begin
    pwrSaveExec <= issue;
    pwrSaveSleep <= toSleep;
  end
endmodule : psmc_cpu_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a,b) begin compares++; if ((a)!==(b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t %h %h", $time, a, b); end end
`define WAITV(c) begin i=0; while (!(c)) begin @(posedge ref_clk); #1; i++; \
  if (i>300) begin n_mismatch++; tally_and_finish(); end end end
module tb;
  import psmc_pkg::*;
  logic ref_clk=0, rst=1, lprcClk=0, psel=0, penable=0, pwrite=0;
  logic [31:0] paddr=0, pwdata=0, prdata, rd;
  logic pready, pslverr, intPending=0, wdtEnable=0, fscmEnable=0;
  logic wdtTimeout=0, onChipOsc=1, issue=0, toSleep=0;
  logic pwrSaveExec, pwrSaveSleep, sysClkRun, oscEnable, lprcEnable;
  logic fscmActive, wdtClear, cpuClkEn, wakeEvent;
  logic [2:0] curOscSel=0, resumeOscSel, osc;
  logic [NUM_MOD-1:0] extClocked=0, perClkEn, perFuncEn, perRegBlock, p;
  int compares=0, n_mismatch=0, i, r, k;
  int unsigned seed=88416;
  initial forever #2 ref_clk = ~ref_clk;
  initial forever #15.5 lprcClk = ~lprcClk;
  psmc_cpu_model cpu (.ref_clk, .issue, .toSleep, .pwrSaveExec, .pwrSaveSleep);
  psmc_top uut (.ref_clk, .rst, .lprcClk, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pwrSaveExec, .pwrSaveSleep,
    .intPending, .wdtEnable, .fscmEnable, .wdtTimeout, .curOscSel,
    .onChipOsc, .extClocked, .sysClkRun, .oscEnable, .lprcEnable,
    .fscmActive, .wdtClear, .cpuClkEn, .perClkEn, .perFuncEn, .perRegBlock,
    .resumeOscSel, .wakeEvent);
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic tally_and_finish();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int t;
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) begin
      n_mismatch++;
      tally_and_finish();
    end
    rd = prdata;
    psel <= 0;
    penable <= 0;
    #1;
  endtask : apb
  task automatic psave(input logic s);
    @(posedge ref_clk);
    issue <= 1;
    toSleep <= s;
    @(posedge ref_clk);
    issue <= 0;
    #1;
  endtask : psave
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    apb(0, CLOCK_DIVIDER_REGISTER_ADDR, 0);
    `CHK(rd, 32'h0)
    apb(0, STAT_ADDR, 0);
    `CHK(rd[2:0], PSMC_RUN)
    for (r = 0; r < 8; r++) begin
      apb(1, CLOCK_DIVIDER_REGISTER_ADDR, (32'h1 << CLOCK_REDUCTION_ENABLE_BIT) | (r << RATIO_LO));
      repeat (4) @(posedge ref_clk);
      k = 0;
      repeat (2 << r) begin
        @(posedge ref_clk);
        #1 k += (cpuClkEn === 1'b1);
      end
      `CHK(k, 2)
      `CHK(perClkEn, 8'hFF)
    end
    for (r = 0; r < 2; r++) begin
      apb(1, CLOCK_DIVIDER_REGISTER_ADDR, (r << ROI_BIT) | 32'h3800);
      @(posedge ref_clk);
      intPending <= 1;
      @(posedge ref_clk);
      intPending <= 0;
      apb(0, CLOCK_DIVIDER_REGISTER_ADDR, 0);
      `CHK(rd, (r << ROI_BIT) | (r ? 32'h3000 : 32'h3800))
    end
    apb(1, CLOCK_DIVIDER_REGISTER_ADDR, 0);
    apb(1, IDL_ADDR, 32'h0F);
    wdtEnable <= 1;
    fscmEnable <= 1;
    psave(0);
    `WAITV(wdtClear === 1'b1)
    repeat (2) @(posedge ref_clk);
    #1 `CHK({cpuClkEn, sysClkRun, lprcEnable}, 3'b011)
    `CHK(perClkEn, 8'hF0)
    apb(0, STAT_ADDR, 0);
    `CHK(rd[2:0], PSMC_IDLE)
    @(posedge ref_clk);
    intPending <= 1;
    `WAITV(wakeEvent === 1'b1)
    @(posedge ref_clk);
    intPending <= 0;
    #1 `CHK(cpuClkEn, 1'b1)
    osc = 3'(xs());
    p = NUM_MOD'(xs());
    @(posedge ref_clk);
    curOscSel <= osc;
    extClocked <= p;
    psave(1);
    `WAITV(wdtClear === 1'b1)
    repeat (2) @(posedge ref_clk);
    #1 `CHK({sysClkRun, oscEnable, fscmActive, cpuClkEn, lprcEnable}, 5'h01)
    `CHK(perClkEn & ~p, 8'h00)
    @(posedge ref_clk);
    curOscSel <= ~osc;
    wdtTimeout <= 1;
    `WAITV(wakeEvent === 1'b1)
    @(posedge ref_clk);
    wdtTimeout <= 0;
    #1 `CHK(resumeOscSel, osc)
    p = NUM_MOD'(xs()) | 8'h01;
    apb(1, PMD_ADDR, p);
    apb(1, EN_ADDR, 0);
    apb(0, EN_ADDR, 0);
    `CHK(rd, BAD_READ)
    `CHK({perClkEn, perRegBlock}, {~p, p})
    apb(1, PMD_ADDR, 0);
    `CHK({perFuncEn, perClkEn}, {p, 8'hFF})
    apb(0, 32'h40, 0);
    `CHK(rd, 32'h0)
    `CHK({pready, pslverr}, 2'b10)
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
